// ==== tcr_consts.vh ====
`ifndef TCR_CONSTS_VH
`define TCR_CONSTS_VH

// ==========================================
// Configuration byte addresses
`define TCR_ADDR_PIN_EN 5'h00
`define TCR_ADDR_MODE 5'h01
`define TCR_ADDR_FIFO 5'h02

// ==========================================
// Pin enable byte fields
`define TCR_PIN_EV_LO 0
`define TCR_PIN_EV_HI 3
`define TCR_PIN_REF 4
`define TCR_PIN_INH 6
`define TCR_PIN_IDXRST 7

// ==========================================
// Mode byte fields
`define TCR_MODE_ACC_LO 0
`define TCR_MODE_ACC_HI 3
`define TCR_MODE_CMB_LO 4
`define TCR_MODE_CMB_HI 5
`define TCR_MODE_HR_LO 6
`define TCR_MODE_HR_HI 7

// ==========================================
// Read-out policy byte fields
`define TCR_FIFO_COMMON 6
`define TCR_FIFO_BLOCK 7

// ==========================================
// Field encodings and reset values
`define TCR_CMB_INDEP 2'h0
`define TCR_CMB_DIST 2'h1
`define TCR_CMB_WIDTH 2'h2
`define TCR_HR_OFF 2'h0
`define TCR_HR_2X 2'h1
`define TCR_HR_4X 2'h2
`define TCR_CFG_RESET 8'h00

`endif

// ==== tcr_chan_queue.v ====
`timescale 1ns/100ps
`include "tcr_consts.vh"

module tcr_chan_queue #(
  parameter DW = 24,
  parameter DEPTH = 8,
  parameter AW = 3
) (
  input wire sys_clk,
  input wire srst,
  input wire hit,
  input wire [DW-1:0] stamp,
  input wire [1:0] hr_sel,
  input wire block_mode,
  input wire pop,
  output wire [DW+1:0] head_data,
  output wire avail,
  output wire busy
);

  reg [DW+1:0] mem [0:DEPTH-1];
  reg [DW+1:0] acc_reg;
  reg [1:0] left_reg;
  reg run_reg;
  reg lock_reg;
  reg [AW-1:0] wr_ptr_reg;
  reg [AW-1:0] rd_ptr_reg;
  reg [AW:0] count_reg;
  wire full;
  wire empty;
  wire start;
  wire push;
  wire do_pop;
  wire [1:0] reps_m1;

  function [1:0] reps_less_one;
    input [1:0] sel;
    begin
      case (sel)
        `TCR_HR_2X: reps_less_one = 2'h1;
        `TCR_HR_4X: reps_less_one = 2'h3;
        default: reps_less_one = 2'h0;
      endcase
    end
  endfunction

  assign full = (count_reg == DEPTH);
  assign empty = (count_reg == {(AW+1){1'b0}});
  assign reps_m1 = reps_less_one(hr_sel);
  // no restart while locked; busy sets the least pulse spacing
  assign start = hit && !run_reg && !lock_reg && !full;
  assign push = (start && reps_m1 == 2'h0) || (run_reg && left_reg == 2'h0);
  assign avail = block_mode ? (lock_reg && !empty) : !empty;
  assign do_pop = pop && avail;
  assign head_data = mem[rd_ptr_reg];
  assign busy = run_reg;

  // ==========================================
  // Repeated measurement and summing
  always @(posedge sys_clk) begin
    if (srst) begin
      run_reg <= 1'b0;
      left_reg <= 2'h0;
      acc_reg <= {(DW+2){1'b0}};
    end else if (start) begin
      acc_reg <= {2'b00, stamp};
      left_reg <= reps_m1 - 2'h1;
      run_reg <= (reps_m1 != 2'h0);
    end else if (run_reg) begin
      acc_reg <= acc_reg + {2'b00, stamp};
      left_reg <= left_reg - 2'h1;
      if (left_reg == 2'h0) begin
        run_reg <= 1'b0;
      end
    end
  end

  // ==========================================
  // Result storage
  always @(posedge sys_clk) begin
    if (push) begin
      mem[wr_ptr_reg] <= start ? {2'b00, stamp} : acc_reg + {2'b00, stamp};
    end
  end

  always @(posedge sys_clk) begin
    if (srst) begin
      wr_ptr_reg <= {AW{1'b0}};
      rd_ptr_reg <= {AW{1'b0}};
      count_reg <= {(AW+1){1'b0}};
      lock_reg <= 1'b0;
    end else begin
      if (push) begin
        wr_ptr_reg <= wr_ptr_reg + {{(AW-1){1'b0}}, 1'b1};
      end
      if (do_pop) begin
        rd_ptr_reg <= rd_ptr_reg + {{(AW-1){1'b0}}, 1'b1};
      end
      if (push && !do_pop) begin
        count_reg <= count_reg + {{AW{1'b0}}, 1'b1};
      end else if (do_pop && !push) begin
        count_reg <= count_reg - {{AW{1'b0}}, 1'b1};
      end
      // lock from full until fully read
      if (block_mode && push && !do_pop && count_reg == DEPTH - 1) begin
        lock_reg <= 1'b1;
      end else if (do_pop && count_reg == {{AW{1'b0}}, 1'b1}) begin
        lock_reg <= 1'b0;
      end else if (!block_mode) begin
        lock_reg <= 1'b0;
      end
    end
  end

endmodule

// ==== tcr_config_top.v ====
`timescale 1ns/100ps
`include "tcr_consts.vh"

// Contract
// - Bits 0..3 of pin byte gate each event input pin.
// - Bit 4 of pin byte enables reference clock input pins.
// - Inhibit gate clear: inhibit pin ignored, measurement follows configuration.
// - Inhibit gate set: no measurements while inhibit pin high.
// - Bit 7 of pin byte enables index counter reset pin.
// - Accept bit clear: channel events dropped; pin gate unchanged.
// - Accept bit set: channel events accepted and processed.
// - Combine 00b keeps both stop channels independent.
// - Combine 01b alternates first-input events between channels A and B.
// - Combine 10b: rising edges to A, falling edges to B.
// - High resolution delays, repeats and sums each event's measurement.
// - High-resolution 00b is single measurement, least pulse spacing.
// - High-resolution 01b measures each event twice.
// - High-resolution 10b measures each event four times.
// - Common-read clear: interrupt low when any queue has data.
// - Common-read set: interrupt low when all active queues have data.
// - Block-read clear: queues run continuously.
// - Block-read set: no output until the queue is full.
// - Block-read: no new measurement until full queue fully read.
// - Configuration bytes reset to zero and are read/write.

module tcr_config_top #(
  parameter IDX_W = 16,
  parameter FINE_W = 8,
  parameter DEPTH = 8,
  parameter AW = 3
) (
  input wire sys_clk,
  input wire srst,
  input wire cfg_wr_en,
  input wire cfg_rd_en,
  input wire [4:0] cfg_addr,
  input wire [7:0] cfg_wr_data,
  output wire [7:0] cfg_rd_data,
  input wire [3:0] event_input,
  input wire reference_clock_input,
  input wire inhibit_input,
  input wire index_counter_reset_input,
  input wire res_rd_en,
  input wire [1:0] res_rd_sel,
  output wire [IDX_W+FINE_W+1:0] res_data,
  output wire res_valid,
  output wire [3:0] chan_avail,
  output wire irq_n
);

  localparam DW = IDX_W + FINE_W;
  localparam SEL_NONE = 3'h0;
  localparam SEL_PIN = 3'h1;
  localparam SEL_MODE = 3'h2;
  localparam SEL_FIFO = 3'h4;

  // ==========================================
  // Byte select, shared by the write and read paths
  function [2:0] byte_sel;
    input [4:0] addr;
    begin
      case (addr)
        `TCR_ADDR_PIN_EN: byte_sel = SEL_PIN;
        `TCR_ADDR_MODE: byte_sel = SEL_MODE;
        `TCR_ADDR_FIFO: byte_sel = SEL_FIFO;
        default: byte_sel = SEL_NONE;
      endcase
    end
  endfunction

  wire [2:0] cfg_sel;
  assign cfg_sel = byte_sel(cfg_addr);

  // ==========================================
  // Configuration bytes
  reg [7:0] input_pin_enables_reg;
  reg [7:0] channel_mode_select_reg;
  reg [7:0] fifo_readout_policy_reg;
  reg [7:0] rd_data_reg;

  wire [3:0] event_pin_gate;
  wire reference_clock_pin_gate;
  wire measurement_inhibit_pin_gate;
  wire index_counter_reset_pin_gate;
  wire [3:0] event_accept;
  wire [1:0] combine_sel;
  wire [1:0] hr_sel;
  wire common_read;
  wire full_queue_block_read;

  assign event_pin_gate = input_pin_enables_reg[`TCR_PIN_EV_HI:`TCR_PIN_EV_LO];
  assign reference_clock_pin_gate = input_pin_enables_reg[`TCR_PIN_REF];
  assign measurement_inhibit_pin_gate = input_pin_enables_reg[`TCR_PIN_INH];
  assign index_counter_reset_pin_gate = input_pin_enables_reg[`TCR_PIN_IDXRST];
  assign event_accept = channel_mode_select_reg[`TCR_MODE_ACC_HI:`TCR_MODE_ACC_LO];
  assign combine_sel = channel_mode_select_reg[`TCR_MODE_CMB_HI:`TCR_MODE_CMB_LO];
  assign hr_sel = channel_mode_select_reg[`TCR_MODE_HR_HI:`TCR_MODE_HR_LO];
  assign common_read = fifo_readout_policy_reg[`TCR_FIFO_COMMON];
  assign full_queue_block_read = fifo_readout_policy_reg[`TCR_FIFO_BLOCK];

  always @(posedge sys_clk) begin
    if (srst) begin
      input_pin_enables_reg <= `TCR_CFG_RESET;
      channel_mode_select_reg <= `TCR_CFG_RESET;
      fifo_readout_policy_reg <= `TCR_CFG_RESET;
    end else if (cfg_wr_en) begin
      // whole byte stored, fixed bits too
      case (cfg_sel)
        SEL_PIN: input_pin_enables_reg <= cfg_wr_data;
        SEL_MODE: channel_mode_select_reg <= cfg_wr_data;
        SEL_FIFO: fifo_readout_policy_reg <= cfg_wr_data;
        default: ;
      endcase
    end
  end

  // Other addresses belong to other blocks and read as zero here
  always @(posedge sys_clk) begin
    if (srst) begin
      rd_data_reg <= `TCR_CFG_RESET;
    end else if (cfg_rd_en) begin
      case (cfg_sel)
        SEL_PIN: rd_data_reg <= input_pin_enables_reg;
        SEL_MODE: rd_data_reg <= channel_mode_select_reg;
        SEL_FIFO: rd_data_reg <= fifo_readout_policy_reg;
        default: rd_data_reg <= `TCR_CFG_RESET;
      endcase
    end
  end

  assign cfg_rd_data = rd_data_reg;

  // ==========================================
  // Pin synchronisers
  reg [3:0] ev_meta_reg;
  reg [3:0] ev_sync_reg;
  reg [3:0] ev_prev_reg;
  reg [2:0] aux_meta_reg;
  reg [2:0] aux_sync_reg;
  reg ref_prev_reg;

  always @(posedge sys_clk) begin
    if (srst) begin
      ev_meta_reg <= 4'h0;
      ev_sync_reg <= 4'h0;
      aux_meta_reg <= 3'h0;
      aux_sync_reg <= 3'h0;
    end else begin
      ev_meta_reg <= event_input;
      ev_sync_reg <= ev_meta_reg;
      aux_meta_reg <= {index_counter_reset_input, inhibit_input, reference_clock_input};
      aux_sync_reg <= aux_meta_reg;
    end
  end

  wire [3:0] ev_live;
  assign ev_live = ev_sync_reg & event_pin_gate;
  wire ref_live;
  assign ref_live = aux_sync_reg[0] & reference_clock_pin_gate;
  // inhibit only when its gate is set
  wire inhibit;
  assign inhibit = aux_sync_reg[1] & measurement_inhibit_pin_gate;
  wire idx_clear;
  assign idx_clear = aux_sync_reg[2] & index_counter_reset_pin_gate;

  always @(posedge sys_clk) begin
    if (srst) begin
      ev_prev_reg <= 4'h0;
      ref_prev_reg <= 1'b0;
    end else begin
      ev_prev_reg <= ev_live;
      ref_prev_reg <= ref_live;
    end
  end

  // Edges taken after the second stage only, so no metastable level reaches a queue
  wire [3:0] ev_rise;
  wire [3:0] ev_fall;
  wire ref_rise;
  assign ev_rise = ev_live & ~ev_prev_reg;
  assign ev_fall = ~ev_live & ev_prev_reg;
  assign ref_rise = ref_live & ~ref_prev_reg;

  // ==========================================
  // Reference index and fine time stamp
  reg [IDX_W-1:0] idx_reg;
  reg [FINE_W-1:0] fine_reg;

  always @(posedge sys_clk) begin
    if (srst) begin
      idx_reg <= {IDX_W{1'b0}};
      fine_reg <= {FINE_W{1'b0}};
    end else begin
      // Reset pin wins over a reference edge in the same cycle
      if (idx_clear) begin
        idx_reg <= {IDX_W{1'b0}};
      end else if (ref_rise) begin
        idx_reg <= idx_reg + {{(IDX_W-1){1'b0}}, 1'b1};
      end
      if (ref_rise || idx_clear) begin
        fine_reg <= {FINE_W{1'b0}};
      end else begin
        fine_reg <= fine_reg + {{(FINE_W-1){1'b0}}, 1'b1};
      end
    end
  end

  wire [DW-1:0] stamp;
  assign stamp = {idx_reg, fine_reg};

  // ==========================================
  // Pair steering, channels 1/2 and 3/4 form pairs A/B
  reg [1:0] alt_reg;
  reg [3:0] hit_raw;
  integer p;

  always @* begin
    hit_raw = 4'h0;
    for (p = 0; p < 2; p = p + 1) begin
      case (combine_sel)
        `TCR_CMB_DIST: begin
          hit_raw[2*p] = ev_rise[2*p] & ~alt_reg[p];
          hit_raw[2*p+1] = ev_rise[2*p] & alt_reg[p];
        end
        `TCR_CMB_WIDTH: begin
          // rising to A, falling to B
          hit_raw[2*p] = ev_rise[2*p];
          hit_raw[2*p+1] = ev_fall[2*p];
        end
        default: begin
          hit_raw[2*p] = ev_rise[2*p];
          hit_raw[2*p+1] = ev_rise[2*p+1];
        end
      endcase
    end
  end

  // Pair always restarts on channel A when pulse distance is entered
  always @(posedge sys_clk) begin
    if (srst || combine_sel != `TCR_CMB_DIST) begin
      alt_reg <= 2'h0;
    end else begin
      alt_reg <= alt_reg ^ {ev_rise[2], ev_rise[0]};
    end
  end

  wire [3:0] hit;
  assign hit = hit_raw & event_accept & {4{~inhibit}};

  // ==========================================
  // Channel queues
  wire [DW+1:0] head [0:3];
  wire [3:0] avail;
  wire [3:0] pop;
  genvar g;

  assign pop = res_rd_en ? (4'h1 << res_rd_sel) : 4'h0;

  generate
    for (g = 0; g < 4; g = g + 1) begin : gen_chan
      tcr_chan_queue #(
        .DW(DW),
        .DEPTH(DEPTH),
        .AW(AW)
      ) u_queue (
        .sys_clk(sys_clk),
        .srst(srst),
        .hit(hit[g]),
        .stamp(stamp),
        .hr_sel(hr_sel),
        .block_mode(full_queue_block_read),
        .pop(pop[g]),
        .head_data(head[g]),
        .avail(avail[g]),
        .busy()
      );
    end
  endgenerate

  assign chan_avail = avail;

  // ==========================================
  // Result read port
  reg [DW+1:0] res_data_reg;
  reg res_valid_reg;

  always @(posedge sys_clk) begin
    if (srst) begin
      res_data_reg <= {(DW+2){1'b0}};
      res_valid_reg <= 1'b0;
    end else begin
      // Read of an empty or withheld channel is dropped, no valid pulse
      res_valid_reg <= res_rd_en & avail[res_rd_sel];
      if (res_rd_en && avail[res_rd_sel]) begin
        res_data_reg <= head[res_rd_sel];
      end
    end
  end

  assign res_data = res_data_reg;
  assign res_valid = res_valid_reg;

  // ==========================================
  // Interrupt, active low
  wire [3:0] active;
  wire any_ready;
  wire all_ready;
  reg irq_n_reg;

  assign active = event_pin_gate & event_accept;
  assign any_ready = |avail;
  // No active channel means common mode never fires
  assign all_ready = (|active) && ((active & ~avail) == 4'h0);
  // Registered so the pin cannot glitch while several queues change at once
  wire irq_n_next;
  assign irq_n_next = common_read ? ~all_ready : ~any_ready;

  always @(posedge sys_clk) begin
    if (srst) begin
      irq_n_reg <= 1'b1;
    end else begin
      irq_n_reg <= irq_n_next;
    end
  end

  assign irq_n = irq_n_reg;

endmodule

// ==== tcr_host_model.sv ====
`timescale 1ns/100ps
// ====================
// Host side of the config bus
module tcr_host_model (
  input wire sys_clk,
  output reg cfg_wr_en = 1'b0,
  output reg cfg_rd_en = 1'b0,
  output reg [4:0] cfg_addr = 5'h00,
  output reg [7:0] cfg_wr_data = 8'h00,
  input wire [7:0] cfg_rd_data
);
  task wr(input [4:0] a, input [7:0] d);
    begin
      cfg_addr <= a;
      cfg_wr_data <= d;
      cfg_wr_en <= 1'b1;
      @(posedge sys_clk);
      cfg_wr_en <= 1'b0;
      @(posedge sys_clk);
    end
  endtask
  task rd(input [4:0] a, output [7:0] q);
    begin
      cfg_addr <= a;
      cfg_rd_en <= 1'b1;
      @(posedge sys_clk);
      cfg_rd_en <= 1'b0;
      @(posedge sys_clk);
      q = cfg_rd_data;
    end
  endtask
endmodule

// ==== tcr_config_top_chk.sv ====
`timescale 1ns/100ps
// ====================
// Port checker
module tcr_config_top_chk (
  input wire sys_clk,
  input wire srst,
  input wire cfg_wr_en,
  input wire cfg_rd_en,
  input wire [4:0] cfg_addr,
  input wire [7:0] cfg_wr_data,
  input wire [7:0] cfg_rd_data,
  input wire inhibit_input,
  input wire res_rd_en,
  input wire [1:0] res_rd_sel,
  input wire res_valid,
  input wire [3:0] chan_avail,
  input wire irq_n
);
  reg [7:0] pin_reg, mode_reg, fifo_reg;
  wire [3:0] act = pin_reg[3:0] & mode_reg[3:0];
  wire [7:0] shad = cfg_addr == 5'h00 ? pin_reg : cfg_addr == 5'h01 ? mode_reg : cfg_addr == 5'h02 ? fifo_reg : 8'h00;
  // No active channel means the line never drops in common-read mode
  wire irq_exp = fifo_reg[6] ? !(act != 4'h0 && (chan_avail & act) == act) : chan_avail == 4'h0;
  always @(posedge sys_clk) begin
    if (srst) begin
      pin_reg <= 8'h00;
      mode_reg <= 8'h00;
      fifo_reg <= 8'h00;
    end else if (cfg_wr_en) begin
      if (cfg_addr == 5'h00) pin_reg <= cfg_wr_data;
      if (cfg_addr == 5'h01) mode_reg <= cfg_wr_data;
      if (cfg_addr == 5'h02) fifo_reg <= cfg_wr_data;
    end
  end
  default clocking cb @(posedge sys_clk); endclocking
  default disable iff (srst);
  reset_clear_a: assert property ($fell(srst) |-> cfg_rd_data == 8'h00 && irq_n && !res_valid && !chan_avail)
    else $error("outputs not cleared by reset");
  readback_a: assert property (cfg_rd_en && !cfg_wr_en |=> cfg_rd_data == $past(shad))
    else $error("read data differs from last write");
  rd_hold_a: assert property (!cfg_rd_en |=> $stable(cfg_rd_data))
    else $error("read data moved without a read");
  result_read_a: assert property (res_valid == $past(res_rd_en && chan_avail[res_rd_sel]))
    else $error("result pulse without a taken read");
  gate_accept_a: assert property ($rose(chan_avail[0]) |-> $past(act[0], 3))
    else $error("data on a gated or rejected channel");
  inhibit_a: assert property ((pin_reg[6] && inhibit_input) [*8] |=> (chan_avail & ~$past(chan_avail)) == 4'h0)
    else $error("measurement while inhibited");
  irq_any_a: assert property (!$past(fifo_reg[6]) |-> irq_n == $past(irq_exp))
    else $error("interrupt wrong in any-queue mode");
  irq_all_a: assert property ($past(fifo_reg[6]) |-> irq_n == $past(irq_exp))
    else $error("interrupt wrong in all-queue mode");
  cover property (!irq_n && fifo_reg[6]);
  cover property (res_valid && fifo_reg[7]);
  cover property (cfg_rd_en && cfg_addr > 5'h02);
endmodule
bind tcr_config_top tcr_config_top_chk chk_u (.sys_clk(sys_clk), .srst(srst), .cfg_wr_en(cfg_wr_en),
  .cfg_rd_en(cfg_rd_en), .cfg_addr(cfg_addr), .cfg_wr_data(cfg_wr_data), .cfg_rd_data(cfg_rd_data),
  .inhibit_input(inhibit_input), .res_rd_en(res_rd_en), .res_rd_sel(res_rd_sel), .res_valid(res_valid),
  .chan_avail(chan_avail), .irq_n(irq_n));

// ==== tcr_config_top_bench.sv ====
`timescale 1ns/100ps
// ====================
// Bench
module tcr_config_top_bench;
  reg sys_clk, srst, ref_in, inh, rst_in, res_rd_en;
  reg [3:0] ev;
  reg [1:0] sel;
  wire cfg_wr_en, cfg_rd_en, res_valid, irq_n;
  wire [4:0] cfg_addr;
  wire [7:0] cfg_wr_data, cfg_rd_data;
  wire [25:0] res_data;
  wire [3:0] chan_avail;
  int mismatches, num_checks, i, n, k;
  reg [7:0] q, d;
  reg [25:0] r;
  tcr_config_top dut_u (.sys_clk(sys_clk), .srst(srst), .cfg_wr_en(cfg_wr_en), .cfg_rd_en(cfg_rd_en),
    .cfg_addr(cfg_addr), .cfg_wr_data(cfg_wr_data), .cfg_rd_data(cfg_rd_data), .event_input(ev),
    .reference_clock_input(ref_in), .inhibit_input(inh), .index_counter_reset_input(rst_in),
    .res_rd_en(res_rd_en), .res_rd_sel(sel), .res_data(res_data), .res_valid(res_valid),
    .chan_avail(chan_avail), .irq_n(irq_n));
  tcr_host_model h (.sys_clk(sys_clk), .cfg_wr_en(cfg_wr_en), .cfg_rd_en(cfg_rd_en), .cfg_addr(cfg_addr),
    .cfg_wr_data(cfg_wr_data), .cfg_rd_data(cfg_rd_data));
  task print_verdict;
    begin
      $display("checks %0d mismatches %0d", num_checks, mismatches);
      if (mismatches == 0 && num_checks > 0)
        $display("Testbench passed");
      else
        $display("Testbench failed");
      $finish;
    end
  endtask
  task chk(input logic [31:0] s, input logic [31:0] e);
    begin
      num_checks++;
      if (s !== e) begin
        mismatches++;
        $display("[ERR] %0t seen %0h expected %0h", $time, s, e);
      end
    end
  endtask
  // fixed bits zero, no 11b field code
  function [7:0] legal(input [1:0] a, input [7:0] v);
    legal = a == 2'd0 ? v & 8'hDF : a == 2'd2 ? v & 8'hC0 : v & ~((v & (v >> 1) & 8'h50) << 1);
  endfunction
  // Sum of reps stamps on successive cycles, fine count f0 at the first
  function [25:0] hr_sum(input int reps, input int idx, input int f0);
    hr_sum = 26'(reps * (idx * 256 + f0) + reps * (reps - 1) / 2);
  endfunction
  task tick(input int c);
    repeat (c) @(posedge sys_clk);
  endtask
  task pulse(input int c);
    begin
      ev[c] <= 1'b1;
      tick(2);
      ev[c] <= 1'b0;
      tick(4);
    end
  endtask
  task refp;
    begin
      ref_in <= 1'b1;
      tick(2);
      ref_in <= 1'b0;
      tick(2);
    end
  endtask
  task cfg(input [7:0] p, input [7:0] m, input [7:0] f);
    begin
      h.wr(5'h00, p);
      h.wr(5'h01, m);
      h.wr(5'h02, f);
      tick(2);
    end
  endtask
  task pop(input [1:0] c, input v);
    begin
      sel <= c;
      res_rd_en <= 1'b1;
      tick(1);
      res_rd_en <= 1'b0;
      tick(1);
      chk(res_valid, v);
      r = res_data;
    end
  endtask
  task wait_av(input [3:0] m);
    begin
      n = 0;
      while ((chan_avail & m) !== m && n < 40) begin
        tick(1);
        n++;
      end
      if (n == 40) begin
        chk(0, 1);
        print_verdict;
      end
    end
  endtask
  task ev_rd;
    begin
      pulse(0);
      wait_av(4'h1);
      pop(2'd0, 1'b1);
    end
  endtask
  // Empty every queue, block mode off so nothing is withheld
  task drain;
    begin
      h.wr(5'h02, 8'h00);
      for (k = 0; k < 4; k++)
        for (n = 0; n < 12 && chan_avail[k] === 1'b1; n++)
          pop(k[1:0], 1'b1);
      chk(chan_avail, 4'h0);
    end
  endtask
  initial begin
    sys_clk = 1'b0;
    forever #5 sys_clk = ~sys_clk;
  end
  initial begin
    {srst, ref_in, inh, rst_in, res_rd_en, ev, sel} = 11'h400;
    mismatches = 0;
    num_checks = 0;
    n = $urandom(46);
    tick(12);
    srst <= 1'b0;
    tick(1);
    h.wr(5'h09, 8'hA5);
    for (i = 0; i < 4; i++) begin
      h.rd(i == 3 ? 5'h09 : i[4:0], q);
      chk(q, 8'h00);
    end
    repeat (20) begin
      i = $urandom % 3;
      d = legal(i[1:0], 8'($urandom));
      h.wr(i[4:0], d);
      h.rd(i[4:0], q);
      chk(q, d);
    end
    cfg(8'h0F, 8'h0F, 8'h00);
    pulse(0);
    wait_av(4'h1);
    chk(chan_avail, 4'h1);
    tick(1);
    chk(irq_n, 1'b0);
    pop(2'd0, 1'b1);
    for (i = 0; i < 2; i++) begin
      cfg(i ? 8'h0F : 8'h0E, i ? 8'h0E : 8'h0F, 8'h00);
      pulse(0);
      tick(4);
      chk(chan_avail, 4'h0);
    end
    inh <= 1'b1;
    for (i = 0; i < 2; i++) begin
      cfg(i ? 8'h0F : 8'h4F, 8'h0F, 8'h00);
      pulse(0);
      tick(4);
      chk(chan_avail[0], i);
    end
    inh <= 1'b0;
    drain;
    cfg(8'h0F, 8'h1F, 8'h00);
    pulse(0);
    chk(chan_avail, 4'h1);
    pulse(0);
    chk(chan_avail, 4'h3);
    drain;
    cfg(8'h0F, 8'h2F, 8'h00);
    pulse(0);
    chk(chan_avail, 4'h3);
    drain;
    cfg(8'h9F, 8'h0F, 8'h00);
    refp;
    rst_in <= 1'b1;
    tick(3);
    rst_in <= 1'b0;
    tick(3);
    ev_rd;
    chk(r[23:8], 16'h0000);
    refp;
    ev_rd;
    chk(r[23:8], 16'h0001);
    h.wr(5'h00, 8'h8F);
    refp;
    ev_rd;
    chk(r[23:8], 16'h0001);
    h.wr(5'h00, 8'h1F);
    for (i = 1; i < 3; i++) begin
      h.wr(5'h01, {i[1:0], 6'h0F});
      refp;
      ev_rd;
      chk(r, hr_sum(2 * i, i + 1, 3));
    end
    cfg(8'h03, 8'h0F, 8'h40);
    pulse(0);
    chk(irq_n, 1'b1);
    pulse(1);
    chk(irq_n, 1'b0);
    drain;
    cfg(8'h04, 8'h0F, 8'h80);
    repeat (7) pulse(2);
    chk(chan_avail[2], 1'b0);
    pulse(2);
    chk(chan_avail[2], 1'b1);
    pop(2'd2, 1'b1);
    pulse(2);
    repeat (7) pop(2'd2, 1'b1);
    chk(chan_avail[2], 1'b0);
    pop(2'd2, 1'b0);
    drain;
    print_verdict;
  end
endmodule
